// file: src/pzr_pkg.sv
// package of constants and types for the page-zero identification and paging bank
package pzr_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;
   localparam int PAGE_W  = 8;
   localparam int TOOL_W  = 24;
   localparam int SADDR_W = 7;
   localparam int SUPPER_W = 5;
   localparam int PIN_W   = 2;

   // ---------------------------------------------------------------
   // low offsets within a page
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_DIE_REV = 8'h00;
   localparam logic [7:0] OFS_PAGE    = 8'h01;
   localparam logic [7:0] OFS_PN_LO   = 8'h02;
   localparam logic [7:0] OFS_PN_HI   = 8'h03;
   localparam logic [7:0] OFS_GRADE   = 8'h04;
   localparam logic [7:0] OFS_REV     = 8'h05;
   localparam logic [7:0] OFS_TOOL0   = 8'h06;
   localparam logic [7:0] OFS_TOOL1   = 8'h07;
   localparam logic [7:0] OFS_TOOL2   = 8'h08;
   localparam logic [7:0] OFS_TEMP    = 8'h09;
   localparam logic [7:0] OFS_PKG     = 8'h0A;
   localparam logic [7:0] OFS_SADDR   = 8'h0B;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int DIE_REV_MSB = 3;
   localparam int SADDR_LSB   = 2;
   localparam int SADDR_MSB   = 6;

   // ---------------------------------------------------------------
   // fixed values and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  PAGE_ZERO       = 8'h00;
   localparam logic [7:0]  PAGE_RESET      = 8'h00;
   localparam logic [7:0]  GRADE_A         = 8'h00;
   localparam logic [7:0]  GRADE_D         = 8'h03;
   localparam logic [7:0]  REV_A           = 8'h00;
   localparam logic [7:0]  REV_B           = 8'h01;
   localparam logic [7:0]  TEMP_INDUSTRIAL = 8'h00;
   localparam logic [7:0]  PKG_QFN44       = 8'h01;
   localparam logic [7:0]  READ_ZERO       = 8'h00;
   localparam logic [23:0] TOOL_RESET      = 24'h000000;
   localparam logic [4:0]  SUPPER_RESET    = 5'h1A;

   // ---------------------------------------------------------------
   // state of the bank
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PAGE_W-1:0]   page;
      logic [TOOL_W-1:0]   tool;
      logic [SUPPER_W-1:0] saddr_up;
      logic [PIN_W-1:0]    pin_meta;
      logic [PIN_W-1:0]    pin_sync;
      logic [DATA_W-1:0]   rdata;
      logic                rd_valid;
      logic                wr_ack;
   } pzr_state_type;

endpackage : pzr_pkg

// file: src/pzr_page_zero_regs.sv
// page-zero identification and paging register bank
`timescale 1ns/10ps

module pzr_page_zero_regs
   import pzr_pkg::*;
#(
   // identification values; defaults are arbitrary
   parameter logic [3:0]  DIE_REV_VALUE = 4'h2,
   parameter logic [15:0] PART_NUMBER   = 16'h1234,
   parameter logic [7:0]  GRADE_VALUE   = GRADE_A,
   parameter logic [7:0]  REV_VALUE     = REV_A
) (
   // clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                reset_n_i,
   // register access port
   input  wire logic [ADDR_W-1:0]   reg_addr_i,
   input  wire logic                reg_wr_i,
   input  wire logic [DATA_W-1:0]   reg_wdata_i,
   input  wire logic                reg_rd_i,
   output logic      [DATA_W-1:0]   reg_rdata_o,
   output logic                     reg_rd_valid_o,
   output logic                     reg_wr_ack_o,
   // address-select pins
   input  wire logic                address_select_pin_high_i,
   input  wire logic                address_select_pin_low_i,
   // derived state
   output logic      [SADDR_W-1:0]  slave_address_o,
   output logic      [PAGE_W-1:0]   page_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   pzr_state_type st_reg;
   pzr_state_type st_next;
   logic          page_zero;
   logic          is_ro;
   logic [7:0]    rd_mux;

   assign page_zero = (st_reg.page == PAGE_ZERO);

   // read-only identification offsets on page zero
   always_comb begin
      is_ro = 1'b0;
      if (page_zero) begin
         case (reg_addr_i)
            OFS_DIE_REV, OFS_PN_LO, OFS_PN_HI, OFS_GRADE,
            OFS_REV, OFS_TEMP, OFS_PKG: is_ro = 1'b1;
            default:                    is_ro = 1'b0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // read multiplexer
   // ---------------------------------------------------------------
   always_comb begin
      rd_mux = READ_ZERO;
      if (reg_addr_i == OFS_PAGE) begin
         rd_mux = st_reg.page;
      end else if (page_zero) begin
         case (reg_addr_i)
            OFS_DIE_REV: rd_mux = {4'h0, DIE_REV_VALUE};
            OFS_PN_LO:   rd_mux = PART_NUMBER[7:0];
            OFS_PN_HI:   rd_mux = PART_NUMBER[15:8];
            OFS_GRADE:   rd_mux = GRADE_VALUE;
            OFS_REV:     rd_mux = REV_VALUE;
            OFS_TOOL0:   rd_mux = st_reg.tool[7:0];
            OFS_TOOL1:   rd_mux = st_reg.tool[15:8];
            OFS_TOOL2:   rd_mux = st_reg.tool[23:16];
            OFS_TEMP:    rd_mux = TEMP_INDUSTRIAL;
            OFS_PKG:     rd_mux = PKG_QFN44;
            OFS_SADDR:   rd_mux = {1'b0, st_reg.saddr_up, 2'b00};
            default:     rd_mux = READ_ZERO;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next          = st_reg;
      // pins come from outside, two flops before use
      st_next.pin_meta = {address_select_pin_high_i, address_select_pin_low_i};
      st_next.pin_sync = st_reg.pin_meta;
      st_next.rd_valid = reg_rd_i;
      st_next.wr_ack   = reg_wr_i;
      if (reg_rd_i) begin
         st_next.rdata = rd_mux;
      end
      if (reg_wr_i) begin
         if (reg_addr_i == OFS_PAGE) begin
            st_next.page = reg_wdata_i;
         end else if (page_zero) begin
            // identification offsets fall to default and keep their value
            case (reg_addr_i)
               OFS_TOOL0: st_next.tool[7:0]   = reg_wdata_i;
               OFS_TOOL1: st_next.tool[15:8]  = reg_wdata_i;
               OFS_TOOL2: st_next.tool[23:16] = reg_wdata_i;
               OFS_SADDR: st_next.saddr_up    = reg_wdata_i[SADDR_MSB:SADDR_LSB];
               default:   st_next.tool        = st_reg.tool;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_reg.page     <= PAGE_RESET;
         st_reg.tool     <= TOOL_RESET;
         st_reg.saddr_up <= SUPPER_RESET;
         st_reg.pin_meta <= 2'h0;
         st_reg.pin_sync <= 2'h0;
         st_reg.rdata    <= READ_ZERO;
         st_reg.rd_valid <= 1'b0;
         st_reg.wr_ack   <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_o     = st_reg.rdata;
   assign reg_rd_valid_o  = st_reg.rd_valid;
   assign reg_wr_ack_o    = st_reg.wr_ack;
   assign slave_address_o = {st_reg.saddr_up, st_reg.pin_sync};
   assign page_o          = st_reg.page;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_page_wr;
      reg_wr_i && (reg_addr_i == OFS_PAGE);
   endsequence

   sequence s_page_rd;
      reg_rd_i && !reg_wr_i && (reg_addr_i == OFS_PAGE);
   endsequence

   sequence s_tool_wr;
      reg_wr_i && !reg_rd_i && page_zero && (reg_addr_i == OFS_TOOL2);
   endsequence

   sequence s_tool_rd;
      reg_rd_i && !reg_wr_i && page_zero && (reg_addr_i == OFS_TOOL2);
   endsequence

   sequence s_p0_rd(logic [7:0] ofs);
      reg_rd_i && !reg_wr_i && page_zero && (reg_addr_i == ofs);
   endsequence

   sequence s_p0_wr(logic [7:0] ofs);
      reg_wr_i && page_zero && (reg_addr_i == ofs);
   endsequence

   property p_page_any;
      s_page_wr |=> (page_o == $past(reg_wdata_i));
   endproperty
   a_page_any: assert property (p_page_any)
      else $error("page write not taken");

   property p_page_read;
      s_page_rd |=> reg_rd_valid_o && (reg_rdata_o == $past(page_o));
   endproperty
   a_page_read: assert property (p_page_read)
      else $error("page read does not return current page");

   property p_page_full;
      (s_page_wr and (reg_wdata_i != PAGE_ZERO)) ##1 !reg_wr_i ##1 s_page_rd
         |=> (reg_rdata_o == $past(reg_wdata_i, 3));
   endproperty
   a_page_full: assert property (p_page_full)
      else $error("page value not kept in all eight bits");

   property p_die_rev;
      s_p0_rd(OFS_DIE_REV) |=> (reg_rdata_o == {4'h0, DIE_REV_VALUE});
   endproperty
   a_die_rev: assert property (p_die_rev)
      else $error("die revision read wrong");

   property p_part_number;
      (s_p0_rd(OFS_PN_LO) |=> (reg_rdata_o == PART_NUMBER[7:0]))
      and (s_p0_rd(OFS_PN_HI) |=> (reg_rdata_o == PART_NUMBER[15:8]));
   endproperty
   a_part_number: assert property (p_part_number)
      else $error("base part number read wrong");

   property p_grade;
      s_p0_rd(OFS_GRADE) |=> (reg_rdata_o == GRADE_VALUE) && (reg_rdata_o <= GRADE_D);
   endproperty
   a_grade: assert property (p_grade)
      else $error("grade read wrong");

   property p_rev;
      s_p0_rd(OFS_REV) |=> (reg_rdata_o == REV_VALUE);
   endproperty
   a_rev: assert property (p_rev)
      else $error("revision letter read wrong");

   property p_tool;
      s_tool_wr ##1 !reg_wr_i ##1 s_tool_rd
         |=> (reg_rdata_o == $past(reg_wdata_i, 3));
   endproperty
   a_tool: assert property (p_tool)
      else $error("tool version byte not kept");

   property p_temp;
      s_p0_rd(OFS_TEMP) |=> (reg_rdata_o == TEMP_INDUSTRIAL);
   endproperty
   a_temp: assert property (p_temp)
      else $error("temperature grade read wrong");

   property p_pkg;
      s_p0_rd(OFS_PKG) |=> (reg_rdata_o == PKG_QFN44);
   endproperty
   a_pkg: assert property (p_pkg)
      else $error("package identifier read wrong");

   property p_saddr;
      reg_wr_i && page_zero && (reg_addr_i == OFS_SADDR)
         |=> (slave_address_o[6:2] == $past(reg_wdata_i[6:2]));
   endproperty
   a_saddr: assert property (p_saddr)
      else $error("slave address upper bits not updated");

   property p_pins;
      $past(reset_n_i, 2) |->
         (slave_address_o[1:0] ==
          $past({address_select_pin_high_i, address_select_pin_low_i}, 2));
   endproperty
   a_pins: assert property (p_pins)
      else $error("slave address low bits do not follow pins");

   property p_ro_write;
      reg_wr_i && is_ro |=> reg_wr_ack_o && $stable(page_o)
         && $stable(st_reg.tool) && $stable(slave_address_o[6:2]);
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("read-only write changed state or was not acknowledged");

   property p_reset_page;
      !$past(reset_n_i) |-> (page_o == PAGE_RESET);
   endproperty
   a_reset_page: assert property (p_reset_page)
      else $error("page not zero after reset");

   property p_rd_timing;
      reg_rd_i |=> reg_rd_valid_o ##1 !reg_rd_valid_o || $past(reg_rd_i);
   endproperty
   a_rd_timing: assert property (p_rd_timing)
      else $error("read answer not a one-cycle pulse");

   property p_wr_ack;
      reg_wr_i |=> reg_wr_ack_o;
   endproperty
   a_wr_ack: assert property (p_wr_ack)
      else $error("write not acknowledged");

   property p_wr_ack_pulse;
      !reg_wr_i |=> !reg_wr_ack_o;
   endproperty
   a_wr_ack_pulse: assert property (p_wr_ack_pulse)
      else $error("write acknowledge without a write");

   property p_rd_hold;
      !reg_rd_i |=> $stable(reg_rdata_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed without a read");

   property p_other_page_rd;
      reg_rd_i && !page_zero && (reg_addr_i != OFS_PAGE)
         |=> (reg_rdata_o == READ_ZERO);
   endproperty
   a_other_page_rd: assert property (p_other_page_rd)
      else $error("read off page zero not zero");

   property p_other_page_wr;
      reg_wr_i && !page_zero && (reg_addr_i != OFS_PAGE)
         |=> $stable(st_reg.tool) && $stable(slave_address_o[SADDR_MSB:SADDR_LSB]);
   endproperty
   a_other_page_wr: assert property (p_other_page_wr)
      else $error("write off page zero changed a register");

   property p_saddr_read;
      s_p0_rd(OFS_SADDR) |=> (reg_rdata_o[7] == 1'b0) && (reg_rdata_o[1:0] == 2'b00)
         && (reg_rdata_o[SADDR_MSB:SADDR_LSB] == $past(slave_address_o[SADDR_MSB:SADDR_LSB]));
   endproperty
   a_saddr_read: assert property (p_saddr_read)
      else $error("slave address register read wrong");

   property p_tool_low;
      s_p0_wr(OFS_TOOL0) |=> (st_reg.tool[7:0] == $past(reg_wdata_i));
   endproperty
   a_tool_low: assert property (p_tool_low)
      else $error("tool version low byte not written");

   property p_tool_mid;
      s_p0_wr(OFS_TOOL1) |=> (st_reg.tool[15:8] == $past(reg_wdata_i));
   endproperty
   a_tool_mid: assert property (p_tool_mid)
      else $error("tool version middle byte not written");

   property p_page_stable;
      !reg_wr_i |=> $stable(page_o);
   endproperty
   a_page_stable: assert property (p_page_stable)
      else $error("page changed without a write");

   property p_rd_wr_same;
      reg_rd_i && reg_wr_i && (reg_addr_i == OFS_PAGE)
         |=> reg_rd_valid_o && (reg_rdata_o == $past(page_o));
   endproperty
   a_rd_wr_same: assert property (p_rd_wr_same)
      else $error("joint read and write of page did not return old page");

endmodule : pzr_page_zero_regs

// file: verif/pzr_host_model.sv
// host-side model of the register access port
`timescale 1ns/10ps

module pzr_host_model
   import pzr_pkg::*;
(
   // clock
   input  wire logic              clk_sys_i,
   // answers from the bank
   input  wire logic [DATA_W-1:0] reg_rdata_i,
   input  wire logic              reg_rd_valid_i,
   input  wire logic              reg_wr_ack_i,
   // requests to the bank
   output logic      [ADDR_W-1:0] reg_addr_o,
   output logic                   reg_wr_o,
   output logic      [DATA_W-1:0] reg_wdata_o,
   output logic                   reg_rd_o
);

   initial begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o    = 1'b0;
   end

   // one-cycle strobe, read and write may share it; answers one edge later
   task automatic xfer(input logic wr, input logic rd, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q, output logic ok);
      @(negedge clk_sys_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = wr;
      reg_rd_o    = rd;
      @(negedge clk_sys_i);
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      // stale qualifiers are not kept after the request
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
      ok = (reg_wr_ack_i === wr) && (reg_rd_valid_i === rd);
      q  = reg_rdata_i;
   endtask : xfer

endmodule : pzr_host_model

// file: verif/tb_pzr_page_zero_regs.sv
// self-checking testbench of the page-zero register bank
`timescale 1ns/10ps

module tb_pzr_page_zero_regs;
   import pzr_pkg::*;

   // identification values, arbitrary
   localparam logic [3:0]  DIE_V = 4'h9;
   localparam logic [15:0] PN_V  = 16'h2718;

   logic             clk_sys_i;
   logic             reset_n_i;
   logic [7:0]       reg_addr_i;
   logic             reg_wr_i;
   logic [7:0]       reg_wdata_i;
   logic             reg_rd_i;
   logic [7:0]       reg_rdata_o;
   logic             reg_rd_valid_o;
   logic             reg_wr_ack_o;
   logic             pin_hi;
   logic             pin_lo;
   logic [6:0]       slave_address_o;
   logic [7:0]       page_o;
   int               n_mismatch;
   int               checks;
   logic [7:0]       q;
   logic             ok;
   logic [7:0]       d;
   logic [7:0]       p;
   logic [23:0]      tv;
   logic [7:0]       ro_list [7] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0A};

   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   pzr_host_model host_u (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o),
      .reg_rd_valid_i(reg_rd_valid_o), .reg_wr_ack_i(reg_wr_ack_o), .reg_addr_o(reg_addr_i),
      .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));

   pzr_page_zero_regs #(.DIE_REV_VALUE(DIE_V), .PART_NUMBER(PN_V), .GRADE_VALUE(GRADE_D),
      .REV_VALUE(REV_B)) dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rd_valid_o(reg_rd_valid_o),
      .reg_wr_ack_o(reg_wr_ack_o), .address_select_pin_high_i(pin_hi),
      .address_select_pin_low_i(pin_lo), .slave_address_o(slave_address_o), .page_o(page_o));

   task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   function automatic logic [7:0] exp_id(input logic [7:0] a);
      case (a)
         8'h00:   return {4'h0, DIE_V};
         8'h02:   return PN_V[7:0];
         8'h03:   return PN_V[15:8];
         8'h04:   return GRADE_D;
         8'h05:   return REV_B;
         8'h09:   return TEMP_INDUSTRIAL;
         8'h0A:   return PKG_QFN44;
         default: return 8'h00;
      endcase
   endfunction : exp_id

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host_u.xfer(1'b0, 1'b1, a, 8'h00, q, ok);
      chk("read answer", ok, 1'b1);
      chk("read data", q, exp);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host_u.xfer(1'b1, 1'b0, a, v, q, ok);
      chk("write ack", ok, 1'b1);
   endtask : wr

   task automatic do_reset();
      reset_n_i = 1'b0;
      repeat (20) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
   endtask : do_reset

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude

   // watchdog, well above the fewer than two hundred cycles of the run
   initial begin
      #160000;
      n_mismatch++;
      conclude();
   end

   initial begin
      n_mismatch = 0;
      checks = 0;
      void'($urandom(32'hF1B45F63));
      {pin_hi, pin_lo} = 2'($urandom);
      do_reset();
      chk("page_o", page_o, PAGE_RESET);
      chk("slave_address_o", slave_address_o, {SUPPER_RESET, pin_hi, pin_lo});
      // ---------------------------------------------------------------
      // fixed identification, writes ignored
      // ---------------------------------------------------------------
      foreach (ro_list[i]) begin
         rd(ro_list[i], exp_id(ro_list[i]));
         wr(ro_list[i], 8'($urandom));
         rd(ro_list[i], exp_id(ro_list[i]));
      end
      // ---------------------------------------------------------------
      // tool version record, three bytes
      // ---------------------------------------------------------------
      for (int i = 0; i < 3; i++) begin
         tv[8*i +: 8] = 8'($urandom);
         wr(8'h06 + 8'(i), tv[8*i +: 8]);
         rd(8'h06 + 8'(i), tv[8*i +: 8]);
      end
      for (int i = 0; i < 3; i++) rd(8'h06 + 8'(i), tv[8*i +: 8]);
      // ---------------------------------------------------------------
      // slave address: upper bits by register, lower by pins
      // ---------------------------------------------------------------
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 8'hFF : 8'($urandom);
         wr(8'h0B, d);
         rd(8'h0B, d & 8'h7C);
         {pin_hi, pin_lo} = 2'(i);
         repeat (3) @(negedge clk_sys_i);
         chk("slave_address_o", slave_address_o, {d[6:2], pin_hi, pin_lo});
      end
      // ---------------------------------------------------------------
      // paging: register mirrored on every page
      // ---------------------------------------------------------------
      for (int k = 0; k < 5; k++) begin
         p = (k == 0) ? 8'hFF : ((k == 1) ? 8'h80 : 8'($urandom));
         wr(8'h01, p);
         chk("page_o", page_o, p);
         rd(8'h01, p);
         rd(8'h00, (p == 8'h00) ? exp_id(8'h00) : 8'h00);
         if (p != PAGE_ZERO) wr(8'h06, ~tv[7:0]);
      end
      wr(8'h01, 8'h3C);
      host_u.xfer(1'b1, 1'b1, 8'h01, 8'hC3, q, ok);
      chk("rw answer", ok, 1'b1);
      chk("rw old page", q, 8'h3C);
      chk("page_o", page_o, 8'hC3);
      wr(8'h01, PAGE_ZERO);
      rd(8'h02, exp_id(8'h02));
      rd(8'h06, tv[7:0]);
      wr(8'h01, 8'h05);
      do_reset();
      chk("page_o", page_o, PAGE_RESET);
      rd(8'h01, PAGE_RESET);
      conclude();
   end

endmodule : tb_pzr_page_zero_regs
